// ### logic/sr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "sr_ctrl_map.svh"
module sr_ctrl
  import sr_ctrl_pkg::*;
#(
  parameter logic [15:0] ON_DELAY = `ON_DELAY_CYC,
  parameter logic [15:0] MIN_ON = `MIN_ON_CYC,
  parameter logic [15:0] DEAD = `DEAD_CYC,
  parameter logic [15:0] OLP_DLY = `OLP_CYC,
  parameter logic [15:0] OVP_DLY = `OVP_CYC,
  parameter logic [15:0] FBO_DLY = `FBO_CYC,
  parameter logic [15:0] LOCK_DLY = 16'(`LOCK_QUAL_CYC),
  parameter logic [15:0] RING_MAX = 16'(`RING_MAX_CYC),
  parameter logic [15:0] REACH_MAX = 16'(`REACH_MAX_CYC)
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Comparator results
  input wire logic i_drain_below_on,
  input wire logic i_drain_above_off,
  input wire logic i_drain_above_raised_off,
  input wire logic i_drain_at_supply,
  input wire logic i_valley,
  input wire logic i_drain_low_gate_open,
  input wire logic i_supply_above_on,
  input wire logic i_supply_below_off,
  input wire logic i_supply_ready,
  input wire logic i_current_over,
  input wire logic i_fb_over,
  input wire logic i_fb_at_ref,
  input wire logic i_fb_below_open,
  input wire logic i_gate_load_low,
  input wire logic i_full_scale,
  input wire logic i_below_burst,
  input wire logic i_above_burst_hys,
  input wire logic [7:0] i_comp_level,
  // Primary side status
  input wire logic i_primary_off,
  input wire logic i_ccm_needed,
  input wire logic i_primary_lockout,
  input wire logic i_primary_restart,
  // Outputs
  output logic o_rect_gate_drive,
  output logic o_switch_request,
  output logic o_comp_short,
  output logic o_bleed_en,
  output logic o_valley_switching,
  output logic o_burst,
  output logic o_overload_trip,
  output logic o_overvolt_trip,
  output logic o_feedback_open_trip,
  output logic o_gate_open_trip,
  output logic o_gate_short_trip,
  output logic o_drain_sense_fault_trip,
  output logic o_supply_lockout
);

  typedef struct packed {
    gate_state_t gst;
    logic [15:0] gcnt;
    logic running;
    logic gate_en;
    logic ccm_off;
    logic olp;
    logic ovp;
    logic fbo;
    logic gop;
    logic gsp;
    logic drain_sense_fault_trip;
    logic [3:0] gop_cnt;
    logic [3:0] miss_cnt;
    logic gated_this;
    logic valley_on;
    logic ring;
    logic [3:0] vcnt;
    logic [15:0] rcnt;
    logic reach_wait;
    logic [15:0] acnt;
    logic req;
    logic drv;
    logic pend;
  } core_t;
  core_t st_reg, st_next;

  logic lock_on, lock_off, olp_cur, olp_fs, ovp_q, fbo_q;
  logic pfm_pulse, pfm_burst, pfm_hf, any_stop, lockout;
  logic any_lock_clr;

  // ----------------------------------------
  // Qualifiers
  // ----------------------------------------
  // Both supply edges filtered against spikes
  qual_timer u_lock_off (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cond(i_supply_below_off), .i_limit(LOCK_DLY),
    .o_done(lock_off));
  qual_timer u_lock_on (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cond(i_supply_above_on), .i_limit(LOCK_DLY),
    .o_done(lock_on));
  qual_timer u_olp_cur (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cond(i_current_over), .i_limit(OLP_DLY),
    .o_done(olp_cur));
  qual_timer u_olp_fs (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cond(i_full_scale), .i_limit(OLP_DLY),
    .o_done(olp_fs));
  qual_timer u_ovp (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cond(i_fb_over), .i_limit(OVP_DLY), .o_done(ovp_q));
  qual_timer u_fbo (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cond(i_supply_ready && i_fb_below_open && st_reg.running),
    .i_limit(FBO_DLY), .o_done(fbo_q));

  assign any_stop = st_reg.olp | st_reg.ovp | st_reg.fbo | st_reg.gop
    | st_reg.gsp | st_reg.drain_sense_fault_trip;

  pfm_gen u_pfm (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_comp_level(i_comp_level), .i_full_scale(i_full_scale),
    .i_below_burst(i_below_burst),
    .i_above_burst_hys(i_above_burst_hys),
    .i_enable(st_reg.running && !any_stop),
    .o_pulse(pfm_pulse), .o_burst(pfm_burst), .o_high_freq(pfm_hf));

  assign lockout = lock_off || !st_reg.running;
  assign any_lock_clr = lock_off || i_primary_lockout;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.req = 1'b0;
    // Supply lockout resets all of st_reg; the qualifier and PFM state is kept
    if (lock_off) begin
      st_next = '0;
      st_next.gst = GATE_IDLE;
    end else if (!st_reg.running) begin
      st_next.running = lock_on;
      st_next.gsp = lock_on && i_gate_load_low;
    end else begin
      // Latched trips
      if (olp_cur || olp_fs) begin
        st_next.olp = 1'b1;
      end else if (i_primary_lockout) begin
        st_next.olp = 1'b0;
      end
      if (ovp_q) begin
        st_next.ovp = 1'b1;
      end else if (i_fb_at_ref) begin
        st_next.ovp = 1'b0;
      end
      if (fbo_q) begin
        st_next.fbo = 1'b1;
      end else if (i_primary_restart) begin
        st_next.fbo = 1'b0;
      end
      // Restart must clear even a saturated open count
      if (i_primary_restart) begin
        st_next.gop = 1'b0;
        st_next.gop_cnt = '0;
        st_next.gsp = 1'b0;
      end
      if (i_primary_lockout) begin
        st_next.drain_sense_fault_trip = 1'b0;
        st_next.miss_cnt = '0;
      end
      // Burst gate block
      if (pfm_burst) begin
        st_next.gate_en = 1'b0;
      end else if (pfm_pulse) begin
        st_next.gate_en = 1'b1;
      end
      // Switching request
      if (pfm_pulse) begin
        st_next.pend = 1'b1;
      end
      if (st_reg.pend && !any_stop && st_reg.gst == GATE_IDLE) begin
        if (!st_reg.valley_on || !pfm_hf || i_valley) begin
          st_next.req = 1'b1;
          st_next.pend = 1'b0;
        end
      end
      if (any_stop) begin
        st_next.pend = 1'b0;
      end
      // Drain-sense miss counter
      if (st_reg.req) begin
        if (st_reg.gated_this) begin
          st_next.miss_cnt = '0;
        end else if (st_reg.miss_cnt + 4'h1 >= `DRAIN_MISS_PULSES) begin
          st_next.drain_sense_fault_trip = 1'b1;
        end else begin
          st_next.miss_cnt = st_reg.miss_cnt + 4'h1;
        end
        st_next.gated_this = 1'b0;
        st_next.ccm_off = 1'b0;
      end
      // Dead time before primary turn-on in CCM
      if (i_ccm_needed && st_reg.pend) begin
        st_next.ccm_off = 1'b1;
      end
      // Gate sequencer
      unique case (st_reg.gst)
        GATE_IDLE: begin
          st_next.drv = 1'b0;
          if (i_primary_off && i_drain_below_on && st_reg.gate_en
              && !any_stop) begin
            st_next.gst = GATE_DLY;
            st_next.gcnt = '0;
            st_next.gated_this = 1'b1;
            st_next.miss_cnt = '0;
          end
        end
        GATE_DLY: begin
          st_next.gcnt = st_reg.gcnt + 16'h0001;
          if (st_reg.gcnt + 16'h0001 >= ON_DELAY) begin
            st_next.gst = GATE_MIN;
            st_next.drv = 1'b1;
            st_next.gcnt = '0;
          end
        end
        GATE_MIN: begin
          st_next.gcnt = st_reg.gcnt + 16'h0001;
          if (i_drain_above_raised_off || st_reg.ccm_off || any_stop) begin
            st_next.gst = GATE_IDLE;
            st_next.drv = 1'b0;
          end else if (st_reg.gcnt + 16'h0001 >= MIN_ON) begin
            st_next.gst = GATE_ON;
          end
        end
        GATE_ON: begin
          if (i_drain_above_off || st_reg.ccm_off || any_stop) begin
            st_next.gst = GATE_IDLE;
            st_next.drv = 1'b0;
          end
        end
      endcase
      // Gate open: driven but i_drain_low_gate_open still set
      if (st_reg.gst == GATE_ON && st_next.gst == GATE_IDLE) begin
        if (st_reg.ring) begin
          st_next.gop_cnt = st_reg.gop_cnt + 4'h1;
          if (st_reg.gop_cnt + 4'h1 >= `GATE_OPEN_CYCLES) begin
            st_next.gop = 1'b1;
          end
        end else begin
          st_next.gop_cnt = '0;
        end
        st_next.reach_wait = 1'b1;
        st_next.acnt = '0;
        st_next.rcnt = '0;
        st_next.vcnt = '0;
      end
      if (st_reg.gst == GATE_ON) begin
        st_next.ring = i_drain_low_gate_open;
      end
      // Valley switching supervision
      if (st_reg.reach_wait) begin
        st_next.acnt = st_reg.acnt + 16'h0001;
        if (i_drain_at_supply) begin
          st_next.reach_wait = 1'b0;
        end else if (st_reg.acnt >= REACH_MAX) begin
          st_next.valley_on = 1'b0;
          st_next.reach_wait = 1'b0;
        end
      end
      if (st_reg.gst == GATE_IDLE && st_reg.pend) begin
        st_next.rcnt = st_reg.rcnt + 16'h0001;
        if (i_valley) begin
          st_next.vcnt = st_reg.vcnt + 4'h1;
        end
      end
      if (!pfm_hf) begin
        st_next.valley_on = 1'b0;
      end else if (i_ccm_needed || st_reg.vcnt > `VALLEY_MAX
                   || st_reg.rcnt > RING_MAX) begin
        st_next.valley_on = 1'b0;
      end else if (st_reg.req) begin
        st_next.valley_on = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.gst <= GATE_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Comparators arrive as synchronous levels
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rect_gate_drive <= 1'b0;
      o_switch_request <= 1'b0;
      o_comp_short <= 1'b0;
      o_bleed_en <= 1'b0;
      o_valley_switching <= 1'b0;
      o_burst <= 1'b1;
      o_overload_trip <= 1'b0;
      o_overvolt_trip <= 1'b0;
      o_feedback_open_trip <= 1'b0;
      o_gate_open_trip <= 1'b0;
      o_gate_short_trip <= 1'b0;
      o_drain_sense_fault_trip <= 1'b0;
      o_supply_lockout <= 1'b1;
    end else begin
      o_rect_gate_drive <= st_next.drv;
      o_switch_request <= st_next.req;
      o_comp_short <= st_next.olp | st_next.drain_sense_fault_trip;
      o_bleed_en <= st_next.ovp;
      o_valley_switching <= st_next.valley_on;
      o_burst <= pfm_burst;
      o_overload_trip <= st_next.olp;
      o_overvolt_trip <= st_next.ovp;
      o_feedback_open_trip <= st_next.fbo;
      o_gate_open_trip <= st_next.gop;
      o_gate_short_trip <= st_next.gsp;
      o_drain_sense_fault_trip <= st_next.drain_sense_fault_trip;
      o_supply_lockout <= !st_next.running;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_BLEED: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_overvolt_trip |-> o_bleed_en) else $error("bleed missing");
  AST_COMP: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_overload_trip |-> o_comp_short) else $error("comp free");
  AST_STOP: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_overload_trip || o_overvolt_trip) |=> !o_switch_request)
    else $error("switch while tripped");
  AST_DCM_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_reg.gst == GATE_ON && i_drain_above_off && !lock_off)
    |=> !o_rect_gate_drive) else $error("gate stayed on");
  AST_RAISED: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_reg.gst == GATE_MIN && i_drain_above_raised_off && !lock_off)
    |=> !o_rect_gate_drive) else $error("min on not cut");
  AST_LOCK: assert property (@(posedge i_mclk) disable iff (i_rst)
    lock_off |=> o_supply_lockout && !o_rect_gate_drive)
    else $error("lockout ignored");
  AST_BURST: assert property (@(posedge i_mclk) disable iff (i_rst)
    (pfm_burst && $past(pfm_burst)) |-> !st_reg.gate_en)
    else $error("gate enabled in burst");
  AST_SHORT: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_gate_short_trip |=> !o_switch_request)
    else $error("switch with short");
  AST_LOWF: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!pfm_hf && !lock_off && st_reg.running) |=> !st_reg.valley_on)
    else $error("valley below limit");
  COV_GATE: cover property (@(posedge i_mclk) st_reg.gst == GATE_ON);
  COV_OLP: cover property (@(posedge i_mclk) o_overload_trip);
  COV_DRAIN_SENSE_FAULT_TRIP: cover property (@(posedge i_mclk) o_drain_sense_fault_trip);
endmodule
`default_nettype wire

// ### logic/sr_ctrl_map.svh
`ifndef SR_CTRL_MAP_SVH
`define SR_CTRL_MAP_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_NS 40
`define VALLEY_MAX 4'h6
`define RING_MAX_NS 20000
`define RING_MAX_CYC ((`RING_MAX_NS) / (`CLK_NS))
`define REACH_MAX_NS 2500
`define REACH_MAX_CYC ((`REACH_MAX_NS) / (`CLK_NS))
`define LOCK_QUAL_NS 10000
`define LOCK_QUAL_CYC (((`LOCK_QUAL_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define GATE_OPEN_CYCLES 4'h8
`define DRAIN_MISS_PULSES 4'h7
`define ON_DELAY_CYC 16'h0002
`define MIN_ON_CYC 16'h000a
`define DEAD_CYC 16'h0002
`define OLP_CYC 16'h1388
`define OVP_CYC 16'h00fa
`define FBO_CYC 16'h1388
`define PERIOD_MAX 16'h0c35
`define PERIOD_MIN 16'h0053
`define PERIOD_HF 16'h0138
`endif

// ### logic/sr_ctrl_pkg.sv
package sr_ctrl_pkg;
  typedef enum logic [3:0] {
    GATE_IDLE = 4'b0001,
    GATE_DLY = 4'b0010,
    GATE_MIN = 4'b0100,
    GATE_ON = 4'b1000
  } gate_state_t;
endpackage

// ### logic/qual_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Condition qualifier: level must hold N
// ----------------------------------------
module qual_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Condition
  input wire logic i_cond,
  input wire logic [W-1:0] i_limit,
  output logic o_done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } qstate_t;
  qstate_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (!i_cond) begin
      state_next.cnt = '0;
      state_next.done = 1'b0;
    end else if (state_reg.cnt >= i_limit) begin
      state_next.done = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign o_done = state_reg.done;
endmodule
`default_nettype wire

// ### logic/pfm_gen.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// PFM period generator with burst gating
// ----------------------------------------
module pfm_gen #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Loop level
  input wire logic [7:0] i_comp_level,
  input wire logic i_full_scale,
  input wire logic i_below_burst,
  input wire logic i_above_burst_hys,
  input wire logic i_enable,
  // Results
  output logic o_pulse,
  output logic o_burst,
  output logic o_high_freq
);
  `include "sr_ctrl_map.svh"
  typedef struct packed {
    logic [W-1:0] cnt;
    logic burst;
    logic pulse;
  } pstate_t;
  pstate_t state_reg, state_next;
  logic [W-1:0] period;

  // Lower level, longer period
  always_comb begin
    if (i_full_scale) begin
      period = `PERIOD_MIN;
    end else begin
      period = W'(`PERIOD_MAX) - W'({i_comp_level, 3'b000});
      if (period < `PERIOD_MIN) begin
        period = `PERIOD_MIN;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.pulse = 1'b0;
    if (i_below_burst) begin
      state_next.burst = 1'b1;
    end else if (state_reg.burst && i_above_burst_hys) begin
      state_next.burst = 1'b0;
      state_next.pulse = i_enable;
      state_next.cnt = '0;
    end
    if (!state_next.burst && !state_reg.burst && i_enable) begin
      if (state_reg.cnt >= period) begin
        state_next.cnt = '0;
        state_next.pulse = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '{cnt: '0, burst: 1'b1, pulse: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end
  assign o_pulse = state_reg.pulse;
  assign o_burst = state_reg.burst;
  assign o_high_freq = (period <= `PERIOD_HF);
endmodule
`default_nettype wire

// ### bench/primary_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Primary switch and rectifier drain model
// ----------------------------------------
module primary_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Request from the secondary
  input wire logic i_switch_request,
  // Scenario control
  input wire logic i_drain_en,
  input wire logic [7:0] i_cond_cyc,
  input wire logic i_raised,
  // Primary state and drain comparators
  output logic o_primary_off,
  output logic o_drain_below_on,
  output logic o_drain_above_off,
  output logic o_drain_above_raised_off
);
  logic [1:0] ph;
  logic [7:0] cnt;
  logic cond;
  // A busy primary drops requests, as the real one would
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ph <= 2'h0;
      cnt <= 8'h00;
    end else if (ph == 2'h0) begin
      cnt <= 8'h00;
      if (i_switch_request) begin
        ph <= 2'h1;
      end
    end else begin
      cnt <= cnt + 8'h01;
      if (ph == 2'h1 && cnt == 8'h04) begin
        ph <= 2'h2;
        cnt <= 8'h00;
      end else if (ph == 2'h2 && cnt >= i_cond_cyc) begin
        ph <= 2'h0;
      end
    end
  end
  // Drain sits above the off threshold unless conducting, and above the raised one only while i_raised is set
  assign cond = i_drain_en && ph == 2'h2 && cnt < i_cond_cyc;
  assign o_primary_off = ph != 2'h1;
  assign o_drain_below_on = cond && cnt == 8'h00;
  assign o_drain_above_off = !cond;
  assign o_drain_above_raised_off = !cond && i_raised;
endmodule
`default_nettype wire

// ### bench/secondary_sr_control_protection_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
`define WAIT_FOR(c, lim) for (wk = 0; wk < (lim) && !(c); wk++) step(1)
module secondary_sr_control_protection_tb;
  localparam int LOCK = 8;
  localparam int OLP = 20;
  localparam int OVP = 8;
  localparam int FBO = 20;
  localparam int TMO = 60000;
  logic i_mclk, i_rst, i_drain_below_on, i_drain_above_off;
  logic i_drain_above_raised_off, i_drain_at_supply, i_valley;
  logic i_drain_low_gate_open, i_supply_above_on, i_supply_below_off;
  logic i_supply_ready, i_current_over, i_fb_over, i_fb_at_ref;
  logic i_fb_below_open, i_gate_load_low, i_full_scale, i_below_burst;
  logic i_above_burst_hys, i_primary_off, i_ccm_needed;
  logic i_primary_lockout, i_primary_restart, drain_en, raised;
  logic [7:0] i_comp_level, cond_cyc;
  logic o_rect_gate_drive, o_switch_request, o_comp_short, o_bleed_en;
  logic o_valley_switching, o_burst, o_overload_trip, o_overvolt_trip;
  logic o_feedback_open_trip, o_gate_open_trip, o_gate_short_trip;
  logic o_drain_sense_fault_trip, o_supply_lockout;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int req_cnt = 0;
  int fall_cnt = 0;
  int wk;
  // Long delays shortened so the timed trips and the supply lockout are reached quickly
  sr_ctrl #(
    .OLP_DLY(16'h0014),
    .OVP_DLY(16'h0008),
    .FBO_DLY(16'h0014),
    .LOCK_DLY(16'h0008)
  ) dut (
    .i_mclk, .i_rst, .i_drain_below_on, .i_drain_above_off,
    .i_drain_above_raised_off, .i_drain_at_supply, .i_valley,
    .i_drain_low_gate_open, .i_supply_above_on, .i_supply_below_off,
    .i_supply_ready, .i_current_over, .i_fb_over, .i_fb_at_ref,
    .i_fb_below_open, .i_gate_load_low, .i_full_scale, .i_below_burst,
    .i_above_burst_hys, .i_comp_level, .i_primary_off, .i_ccm_needed,
    .i_primary_lockout, .i_primary_restart, .o_rect_gate_drive,
    .o_switch_request, .o_comp_short, .o_bleed_en, .o_valley_switching,
    .o_burst, .o_overload_trip, .o_overvolt_trip, .o_feedback_open_trip,
    .o_gate_open_trip, .o_gate_short_trip, .o_drain_sense_fault_trip,
    .o_supply_lockout
  );
  primary_model partner (
    .i_mclk, .i_rst, .i_switch_request(o_switch_request),
    .i_drain_en(drain_en), .i_cond_cyc(cond_cyc), .i_raised(raised),
    .o_primary_off(i_primary_off), .o_drain_below_on(i_drain_below_on),
    .o_drain_above_off(i_drain_above_off),
    .o_drain_above_raised_off(i_drain_above_raised_off)
  );
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // Event counters and hang guard
  // ----------------------------------------
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_switch_request === 1'b1)
      req_cnt <= req_cnt + 1;
    if ($fell(o_rect_gate_drive))
      fall_cnt <= fall_cnt + 1;
    if (cyc == TMO) begin
      failures++;
      wrap_up();
    end
  end
  task step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task kick(input bit lockout);
    if (lockout)
      i_primary_lockout = 1'b1;
    else
      i_primary_restart = 1'b1;
    step(1);
    {i_primary_lockout, i_primary_restart} = 2'h0;
    step(2);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_start;
    i_rst = 1'b1;
    step(5);
    `CHK({o_burst, o_supply_lockout, o_rect_gate_drive}, 3'h6)
    i_rst = 1'b0;
    i_supply_above_on = 1'b1;
    step(LOCK - 2);
    `CHK(o_supply_lockout, 1'b1)
    `WAIT_FOR(!o_supply_lockout, 8);
    `CHK({o_supply_lockout, o_gate_short_trip}, 2'h0)
    i_supply_below_off = 1'b1;
    step(LOCK - 3);
    i_supply_below_off = 1'b0;
    step(4);
    `CHK(o_supply_lockout, 1'b0)
  endtask
  task t_burst;
    int n;
    {i_below_burst, i_above_burst_hys} = 2'h2;
    step(3);
    `CHK(o_burst, 1'b1)
    n = req_cnt;
    step(1200);
    i_below_burst = 1'b0;
    step(20);
    `CHK(req_cnt, n)
    i_above_burst_hys = 1'b1;
    `WAIT_FOR(o_switch_request, 3);
    `CHK(o_switch_request, 1'b1)
    `WAIT_FOR(o_rect_gate_drive, 40);
    `CHK(o_rect_gate_drive, 1'b1)
    `CHK(o_valley_switching, 1'b0)
  endtask
  task t_period(input logic [7:0] lvl);
    int t0, e;
    i_comp_level = lvl;
    e = 3125 - 8 * int'(lvl);
    `WAIT_FOR(o_switch_request, 4000);
    step(1);
    `WAIT_FOR(o_switch_request, 4000);
    t0 = cyc;
    step(1);
    `WAIT_FOR(o_switch_request, 4000);
    `CHK(((cyc - t0) inside {[e - 1:e + 1]}), 1'b1)
  endtask
  task t_gate;
    i_comp_level = 8'hff;
    `WAIT_FOR(i_drain_below_on, 4000);
    step(2);
    `CHK(o_rect_gate_drive, 1'b0)
    step(1);
    `CHK(o_rect_gate_drive, 1'b1)
    `WAIT_FOR(i_drain_above_off, 40);
    `CHK(o_rect_gate_drive, 1'b1)
    step(1);
    `CHK(o_rect_gate_drive, 1'b0)
  endtask
  // Early drain rise: only the raised threshold may cut min on time
  task t_min_on;
    {cond_cyc, raised} = {8'h05, 1'b0};
    `WAIT_FOR(i_drain_below_on, 4000);
    `WAIT_FOR(i_drain_above_off, 40);
    step(5);
    `CHK(o_rect_gate_drive, 1'b1)
    `WAIT_FOR(!o_rect_gate_drive, 12);
    `CHK(o_rect_gate_drive, 1'b0)
    raised = 1'b1;
    `WAIT_FOR(i_drain_below_on, 4000);
    `WAIT_FOR(i_drain_above_off, 40);
    step(2);
    `CHK(o_rect_gate_drive, 1'b0)
    cond_cyc = 8'h14;
  endtask
  task t_overload;
    int n;
    i_current_over = 1'b1;
    step(OLP - 4);
    `CHK(o_overload_trip, 1'b0)
    `WAIT_FOR(o_overload_trip, 10);
    `CHK({o_overload_trip, o_comp_short}, 2'h3)
    i_current_over = 1'b0;
    n = req_cnt;
    step(1200);
    `CHK({req_cnt == n, o_overload_trip}, 2'h3)
    kick(1'b1);
    `CHK({o_overload_trip, o_comp_short}, 2'h0)
    i_full_scale = 1'b1;
    step(OLP - 4);
    `CHK(o_overload_trip, 1'b0)
    `WAIT_FOR(o_overload_trip, 10);
    `CHK(o_overload_trip, 1'b1)
    i_full_scale = 1'b0;
    step(2);
    kick(1'b1);
  endtask
  task t_ovp;
    int n;
    {i_fb_at_ref, i_fb_over} = 2'h1;
    step(OVP - 3);
    i_fb_over = 1'b0;
    step(4);
    `CHK(o_overvolt_trip, 1'b0)
    i_fb_over = 1'b1;
    step(OVP - 3);
    `CHK(o_overvolt_trip, 1'b0)
    `WAIT_FOR(o_overvolt_trip, 8);
    `CHK({o_overvolt_trip, o_bleed_en}, 2'h3)
    i_fb_over = 1'b0;
    n = req_cnt;
    step(1200);
    `CHK({req_cnt == n, o_overvolt_trip}, 2'h3)
    i_fb_at_ref = 1'b1;
    `WAIT_FOR(!o_overvolt_trip, 5);
    `CHK({o_overvolt_trip, o_bleed_en}, 2'h0)
  endtask
  task t_fbo;
    i_fb_below_open = 1'b1;
    step(FBO + 6);
    `CHK(o_feedback_open_trip, 1'b0)
    i_supply_ready = 1'b1;
    step(FBO - 4);
    `CHK(o_feedback_open_trip, 1'b0)
    `WAIT_FOR(o_feedback_open_trip, 10);
    `CHK(o_feedback_open_trip, 1'b1)
    {i_fb_below_open, i_supply_ready} = 2'h0;
    step(2);
    kick(1'b0);
    `CHK(o_feedback_open_trip, 1'b0)
  endtask
  task t_gate_open;
    int n;
    `WAIT_FOR(o_switch_request, 4000);
    i_drain_low_gate_open = 1'b1;
    n = fall_cnt;
    `WAIT_FOR(fall_cnt == n + 7, 9000);
    step(2);
    `CHK(o_gate_open_trip, 1'b0)
    `WAIT_FOR(fall_cnt == n + 8, 1200);
    step(2);
    `CHK(o_gate_open_trip, 1'b1)
    i_drain_low_gate_open = 1'b0;
    step(1200);
    `CHK(o_gate_open_trip, 1'b1)
    kick(1'b0);
    `CHK(o_gate_open_trip, 1'b0)
  endtask
  // Pulse in flight is gated; each miss is judged at the next request
  task t_drain_fault;
    int n;
    `WAIT_FOR(o_rect_gate_drive, 4000);
    drain_en = 1'b0;
    n = req_cnt;
    `WAIT_FOR(req_cnt == n + 7, 8400);
    step(3);
    `CHK(o_drain_sense_fault_trip, 1'b0)
    `WAIT_FOR(req_cnt == n + 8, 1200);
    step(3);
    `CHK({o_drain_sense_fault_trip, o_comp_short}, 2'h3)
    drain_en = 1'b1;
    n = req_cnt;
    kick(1'b0);
    step(1200);
    `CHK({req_cnt == n, o_drain_sense_fault_trip}, 2'h3)
    {i_supply_above_on, i_supply_below_off} = 2'h1;
    step(LOCK + 4);
    `CHK({o_supply_lockout, o_drain_sense_fault_trip}, 2'h2)
    {i_supply_above_on, i_supply_below_off, i_gate_load_low} = 3'h5;
    `WAIT_FOR(!o_supply_lockout, LOCK + 6);
    step(3);
    `CHK(o_gate_short_trip, 1'b1)
    n = req_cnt;
    step(1200);
    `CHK(req_cnt, n)
    i_gate_load_low = 1'b0;
    kick(1'b0);
    `CHK(o_gate_short_trip, 1'b0)
  endtask
  initial begin
    {i_drain_at_supply, i_valley, i_drain_low_gate_open, i_supply_above_on,
     i_supply_below_off, i_supply_ready, i_current_over, i_fb_over,
     i_fb_below_open, i_gate_load_low, i_full_scale, i_below_burst,
     i_ccm_needed, i_primary_lockout, i_primary_restart} = 15'h0000;
    {i_fb_at_ref, i_above_burst_hys, drain_en, raised} = 4'hf;
    {i_comp_level, cond_cyc} = {8'hff, 8'h14};
    t_start();
    t_burst();
    t_period(8'hff);
    t_period(8'h80);
    t_gate();
    t_min_on();
    t_overload();
    t_ovp();
    t_fbo();
    t_gate_open();
    t_drain_fault();
    wrap_up();
  end
endmodule
`default_nettype wire
